// File: spi_cfg_pkg.sv
// Constants and types shared by the serial port configuration block.
// Assumes word-wide Wishbone access with 8-bit registers in the low byte.
package spi_cfg_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] CFG1_IDX = 8'he8;
    localparam logic [7:0] CFG2_IDX = 8'he9;
    localparam logic [7:0] TXD_IDX = 8'hf0;
    localparam logic [7:0] RXD_IDX = 8'hf1;
    localparam logic [7:0] STAT_IDX = 8'hf2;

    localparam logic [7:0] CFG1_RST = 8'h10;
    localparam logic [7:0] CFG2_RST = 8'h01;

    // Status register bit positions
    localparam int STAT_TX_FULL = 0;
    localparam int STAT_RX_FULL = 1;
    localparam int STAT_BUSY = 7;

    // Half serial clock period in core cycles for rate code 0
    localparam logic [6:0] HALF_BASE = 7'h04;
    localparam logic [4:0] LAST_EDGE = 5'h0f;

    typedef struct packed {
        logic [1:0] reserved;
        logic intmod;
        logic auto_ss;
        logic ss_en;
        logic rx_overwrite;
        logic [1:0] rate;
    } cfg_one_type;

    typedef struct packed {
        logic continuous_transfer_enable;
        logic interface_enable;
        logic open_drain_select;
        logic master_role_select;
        logic clock_polarity_select;
        logic clock_phase_select;
        logic lsb_first;
        logic timode;
    } cfg_two_type;

    // Static settings handed to the link-side slave logic
    typedef struct packed {
        logic clock_polarity_select;
        logic clock_phase_select;
        logic lsb_first;
    } link_cfg_type;

    typedef enum logic [2:0] {
        MST_IDLE = 3'b001,
        MST_RUN = 3'b010,
        MST_GAP = 3'b100
    } mst_state_type;

endpackage

// File: spi_sync2.sv
// Two-stage synchroniser for a group of level signals.
// Assumes each bit changes slowly against the destination clock.
`timescale 1ns/1ps
module spi_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule

// File: spi_slave_link.sv
// Slave-role shifter clocked by the serial clock of the external master.
// Assumes the settings and transmit byte hold still while selected.
`timescale 1ns/1ps
module spi_slave_link
    import spi_cfg_pkg::*;
(
    input wire logic sclk_in,
    input wire logic arst_n_in,
    input wire logic sel_in,
    input wire logic mosi_in,
    input wire spi_cfg_pkg::link_cfg_type cfg_in,
    input wire logic [7:0] tx_byte_in,
    output logic miso_out,
    output logic [7:0] rx_byte_out,
    output logic rx_toggle_out
);
    logic samp_clk;
    logic frame_rst_n;
    logic [2:0] scnt_ff;
    logic [2:0] lcnt_ff;
    logic [7:0] rsh_ff;
    logic [7:0] rx_ff;
    logic tog_ff;
    logic [2:0] idx;
    logic [7:0] rnext;

    // Rising edge of samp_clk always samples, falling always launches
    assign samp_clk = sclk_in ^ cfg_in.clock_polarity_select
        ^ cfg_in.clock_phase_select;
    assign frame_rst_n = arst_n_in & sel_in;
    assign rnext = cfg_in.lsb_first ? {mosi_in, rsh_ff[7:1]}
        : {rsh_ff[6:0], mosi_in};

    // Sample count and receive shifter restart with every selection
    always_ff @(posedge samp_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            scnt_ff <= 3'h0;
            rsh_ff <= 8'h00;
        end
        else
        begin
            scnt_ff <= scnt_ff + 3'h1;
            rsh_ff <= rnext;
        end
    end

    // Byte result and event toggle survive deselection
    always_ff @(posedge samp_clk or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rx_ff <= 8'h00;
            tog_ff <= 1'b0;
        end
        else if (sel_in && scnt_ff == 3'h7)
        begin
            rx_ff <= rnext;
            tog_ff <= ~tog_ff;
        end
    end

    always_ff @(negedge samp_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            lcnt_ff <= 3'h0;
        else
            lcnt_ff <= lcnt_ff + 3'h1;
    end

    // Phase 0 presents the first bit at selection; phase 1 on the first edge
    assign idx = cfg_in.clock_phase_select ? lcnt_ff - 3'h1
        : lcnt_ff;
    assign miso_out = cfg_in.lsb_first ? tx_byte_in[idx]
        : tx_byte_in[3'h7 - idx];
    assign rx_byte_out = rx_ff;
    assign rx_toggle_out = tog_ff;
endmodule

// File: spi_mode_configuration.sv
// Serial peripheral port with its two configuration registers.
// Assumes a classic Wishbone master on CLOCK_IN and a serial partner.
//
// Summary of operation
// - Without continuous mode the master sends one byte, releases select and idles a gap.
// - In continuous mode the master keeps sending while the buffer holds data, select held low.
// - The interface enable bit turns off every pin driver at 0, not the pull-up control, and resets to 0.
// - The open-drain bit at 0 selects internal pull-ups, at 1 open-drain outputs.
// - The master select bit makes the port a slave at 0 and a master at 1, slave by default.
// - Polarity 0 idles the serial clock low so the first edge rises.
// - Polarity 1 idles the serial clock high so the first edge falls.
// - The phase bit picks the launching edge and data is sampled on the other one.
// - Phase 0 samples on the first and every second edge and launches on the others.
// - Phase 1 launches on the first and every second edge and samples on the others.
`timescale 1ns/1ps
module spi_mode_configuration
    import spi_cfg_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    // Wishbone slave
    input wire logic CYC_IN,
    input wire logic STB_IN,
    input wire logic WE_IN,
    input wire logic [11:0] ADR_IN,
    input wire logic [3:0] SEL_IN,
    input wire logic [31:0] DAT_IN,
    output logic [31:0] DAT_OUT,
    output logic ACK_OUT,
    // Serial clock pin
    input wire logic SCLK_IN,
    output logic SCLK_OUT,
    output logic SCLK_OE_OUT,
    // Data pins
    input wire logic MOSI_IN,
    output logic MOSI_OUT,
    output logic MOSI_OE_OUT,
    input wire logic MISO_IN,
    output logic MISO_OUT,
    output logic MISO_OE_OUT,
    // Slave select pin
    input wire logic SS_N_IN,
    output logic SS_N_OUT,
    output logic SS_N_OE_OUT,
    // Pad pull-up control
    output logic PULLUP_EN_OUT
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic tx_full;
        logic rx_full;
        logic ack;
        mst_state_type st;
        logic [6:0] div;
        logic [4:0] edge_cnt;
        logic [7:0] tsh;
        logic [7:0] rsh;
        logic sclk;
        logic mosi;
        logic tog_seen;
    } core_state_type;

    core_state_type s_ff;
    core_state_type nxt_s;
    cfg_one_type c1;
    cfg_two_type c2;
    link_cfg_type lcfg;
    logic [7:0] word_adr;
    logic req;
    logic [6:0] half;
    logic slave_sel;
    logic link_sel;
    logic link_miso;
    logic [7:0] link_rx;
    logic link_tog;
    logic [2:0] sync_in;
    logic [2:0] sync_out;
    logic miso_s;
    logic sel_s;
    logic tog_s;
    logic slave_done;
    logic got_byte;
    logic [7:0] got_val;
    logic [7:0] rd;

    assign c1 = cfg_one_type'(s_ff.cfg1);
    assign c2 = cfg_two_type'(s_ff.cfg2);
    assign lcfg = '{clock_polarity_select: c2.clock_polarity_select,
                    clock_phase_select: c2.clock_phase_select,
                    lsb_first: c2.lsb_first};
    assign word_adr = ADR_IN[9:2];
    assign req = CYC_IN && STB_IN && ADR_IN[11:10] == 2'b00;
    assign half = HALF_BASE << c1.rate;

    // Slave is selected by the pin only when its input is enabled
    assign slave_sel = c2.interface_enable && !c2.master_role_select
        && (!c1.ss_en || !SS_N_IN);
    assign link_sel = slave_sel;

    spi_slave_link u_link (
        .sclk_in(SCLK_IN),
        .arst_n_in(ARST_N_IN),
        .sel_in(link_sel),
        .mosi_in(MOSI_IN),
        .cfg_in(lcfg),
        .tx_byte_in(s_ff.txd),
        .miso_out(link_miso),
        .rx_byte_out(link_rx),
        .rx_toggle_out(link_tog)
    );

    assign sync_in = {link_tog, slave_sel, MISO_IN};

    spi_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(CLOCK_IN),
        .arst_n_in(ARST_N_IN),
        .d_in(sync_in),
        .q_out(sync_out)
    );

    assign miso_s = sync_out[0];
    assign sel_s = sync_out[1];
    assign tog_s = sync_out[2];
    // Link byte is stable long before its toggle arrives here
    assign slave_done = tog_s != s_ff.tog_seen;

    function automatic logic out_bit(input logic [7:0] v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] v,
                                             input logic lsb);
        shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
    endfunction

    // Open drain releases the pin for a high level
    function automatic logic pin_oe(input logic drive, input logic odo,
                                    input logic val);
        pin_oe = drive && (!odo || !val);
    endfunction

    always_comb
    begin
        nxt_s = s_ff;
        got_byte = 1'b0;
        got_val = 8'h00;
        nxt_s.ack = req && !s_ff.ack;
        nxt_s.tog_seen = tog_s;

        // Master engine
        unique case (s_ff.st)
            MST_IDLE:
            begin
                nxt_s.sclk = c2.clock_polarity_select;
                if (c2.interface_enable && c2.master_role_select
                    && s_ff.tx_full)
                begin
                    nxt_s.st = MST_RUN;
                    nxt_s.tx_full = 1'b0;
                    nxt_s.div = half - 7'h1;
                    nxt_s.edge_cnt = 5'h00;
                    nxt_s.tsh = s_ff.txd;
                    if (!c2.clock_phase_select)
                    begin
                        nxt_s.mosi = out_bit(s_ff.txd, c2.lsb_first);
                        nxt_s.tsh = shift_out(s_ff.txd, c2.lsb_first);
                    end
                end
            end
            MST_RUN:
            begin
                if (!c2.interface_enable || !c2.master_role_select)
                    nxt_s.st = MST_IDLE;
                else if (s_ff.div != 7'h00)
                    nxt_s.div = s_ff.div - 7'h1;
                else
                begin
                    nxt_s.div = half - 7'h1;
                    nxt_s.sclk = ~s_ff.sclk;
                    nxt_s.edge_cnt = s_ff.edge_cnt + 5'h01;
                    if (s_ff.edge_cnt[0] == c2.clock_phase_select)
                        nxt_s.rsh = c2.lsb_first
                            ? {miso_s, s_ff.rsh[7:1]}
                            : {s_ff.rsh[6:0], miso_s};
                    else if (s_ff.edge_cnt != LAST_EDGE)
                    begin
                        nxt_s.mosi = out_bit(s_ff.tsh, c2.lsb_first);
                        nxt_s.tsh = shift_out(s_ff.tsh,
                                              c2.lsb_first);
                    end
                    if (s_ff.edge_cnt == LAST_EDGE)
                    begin
                        got_byte = 1'b1;
                        got_val = nxt_s.rsh;
                        nxt_s.edge_cnt = 5'h00;
                        if (c2.continuous_transfer_enable && s_ff.tx_full)
                        begin
                            nxt_s.tx_full = 1'b0;
                            nxt_s.tsh = s_ff.txd;
                            if (!c2.clock_phase_select)
                            begin
                                nxt_s.mosi = out_bit(s_ff.txd, c2.lsb_first);
                                nxt_s.tsh = shift_out(s_ff.txd,
                                                      c2.lsb_first);
                            end
                        end
                        else
                        begin
                            nxt_s.st = MST_GAP;
                            nxt_s.div = {half[5:0], 1'b0} - 7'h1;
                        end
                    end
                end
            end
            MST_GAP:
            begin
                if (s_ff.div != 7'h00)
                    nxt_s.div = s_ff.div - 7'h1;
                else
                    nxt_s.st = MST_IDLE;
            end
            default:
                nxt_s.st = MST_IDLE;
        endcase

        // Slave byte finished: it consumed the buffered transmit byte
        if (slave_done)
        begin
            got_byte = 1'b1;
            got_val = link_rx;
            nxt_s.tx_full = 1'b0;
        end

        // Register writes and reads
        if (req && !s_ff.ack)
        begin
            if (WE_IN && SEL_IN[0])
            begin
                if (word_adr == CFG1_IDX)
                    nxt_s.cfg1 = DAT_IN[7:0];
                if (word_adr == CFG2_IDX)
                    nxt_s.cfg2 = DAT_IN[7:0];
                if (word_adr == TXD_IDX)
                begin
                    nxt_s.txd = DAT_IN[7:0];
                    nxt_s.tx_full = 1'b1;
                end
            end
            if (!WE_IN && word_adr == RXD_IDX)
                nxt_s.rx_full = 1'b0;
        end

        // Received byte wins over a same-cycle read clear
        if (got_byte && (!s_ff.rx_full || c1.rx_overwrite
                         || !nxt_s.rx_full))
        begin
            nxt_s.rxd = got_val;
            nxt_s.rx_full = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            s_ff <= '{cfg1: CFG1_RST, cfg2: CFG2_RST, st: MST_IDLE,
                      default: '0};
        end
        else
            s_ff <= nxt_s;
    end

    always_comb
    begin
        rd = 8'h00;
        unique case (word_adr)
            CFG1_IDX: rd = s_ff.cfg1;
            CFG2_IDX: rd = s_ff.cfg2;
            TXD_IDX: rd = s_ff.txd;
            RXD_IDX: rd = s_ff.rxd;
            STAT_IDX:
            begin
                rd[STAT_TX_FULL] = s_ff.tx_full;
                rd[STAT_RX_FULL] = s_ff.rx_full;
                rd[STAT_BUSY] = s_ff.st != MST_IDLE || sel_s;
            end
            default: rd = 8'h00;
        endcase
    end

    assign ACK_OUT = s_ff.ack;
    assign DAT_OUT = s_ff.ack ? {24'h000000, rd} : 32'h00000000;

    // Pins: master drives clock, data and select; slave drives only data
    assign SCLK_OUT = s_ff.sclk;
    assign SCLK_OE_OUT = pin_oe(c2.interface_enable
        && c2.master_role_select, c2.open_drain_select, s_ff.sclk);
    assign MOSI_OUT = s_ff.mosi;
    assign MOSI_OE_OUT = pin_oe(c2.interface_enable
        && c2.master_role_select, c2.open_drain_select, s_ff.mosi);
    assign SS_N_OUT = c1.auto_ss ? s_ff.st != MST_RUN : 1'b0;
    assign SS_N_OE_OUT = pin_oe(c2.interface_enable
        && c2.master_role_select, c2.open_drain_select, SS_N_OUT);
    assign MISO_OUT = link_miso;
    assign MISO_OE_OUT = pin_oe(slave_sel, c2.open_drain_select,
                                link_miso);
    assign PULLUP_EN_OUT = !c2.open_drain_select;
endmodule

// File: spi_mode_configuration_properties.sv
// Checker for the serial port block; sees only its top-level ports.
// Assumes a register write lands by the edge that samples its ack.
`timescale 1ns/1ps
module spi_mode_configuration_checker
    import spi_cfg_pkg::*;
(
    // Clock, reset and bus
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    input wire logic CYC_IN,
    input wire logic STB_IN,
    input wire logic WE_IN,
    input wire logic [11:0] ADR_IN,
    input wire logic [3:0] SEL_IN,
    input wire logic [31:0] DAT_IN,
    input wire logic ACK_OUT,
    // Pins
    input wire logic SCLK_OUT,
    input wire logic SCLK_OE_OUT,
    input wire logic MOSI_OUT,
    input wire logic MOSI_OE_OUT,
    input wire logic SS_N_OUT,
    input wire logic SS_N_OE_OUT,
    input wire logic PULLUP_EN_OUT
);
    cfg_two_type c2_ff;
    logic [1:0] age_ff;
    logic [9:0] low_ff;
    logic wr2;
    logic mst;
    logic ok;
    assign wr2 = CYC_IN && STB_IN && WE_IN
        && ADR_IN == {2'b00, CFG2_IDX, 2'b00};
    assign mst = c2_ff.interface_enable && c2_ff.master_role_select;
    assign ok = age_ff == 2'h3;
    // Shadow settings, their age, and select low time
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            c2_ff <= 8'h01;
            age_ff <= 2'h0;
            low_ff <= 10'h000;
        end
        else
        begin
            if (wr2 && ACK_OUT && SEL_IN[0])
                c2_ff <= DAT_IN[7:0];
            age_ff <= wr2 ? 2'h0 : age_ff + {1'b0, age_ff != 2'h3};
            low_ff <= SS_N_OUT ? 10'h000 : low_ff + 10'h001;
        end
    end
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    a_off_quiet: assert property (ok && !c2_ff.interface_enable
        |-> !(SCLK_OE_OUT || MOSI_OE_OUT || SS_N_OE_OUT))
        else $error("pin driven while disabled");
    a_pull_sel: assert property (
        ok |-> PULLUP_EN_OUT == !c2_ff.open_drain_select)
        else $error("pull-up control wrong");
    a_od_low: assert property (ok && c2_ff.open_drain_select
        |-> !(SCLK_OE_OUT && SCLK_OUT) && !(MOSI_OE_OUT && MOSI_OUT))
        else $error("open-drain pin driven high");
    a_slave_quiet: assert property (
        ok && !c2_ff.master_role_select
        |-> !SCLK_OE_OUT && !MOSI_OE_OUT)
        else $error("slave drives clock or data out");
    a_idle_pol: assert property (ok && mst && $fell(SS_N_OUT)
        |-> SCLK_OUT == c2_ff.clock_polarity_select)
        else $error("clock not idle at start");
    a_gap_min: assert property (
        mst && !c2_ff.continuous_transfer_enable && $rose(SS_N_OUT)
        |=> SS_N_OUT [*7])
        else $error("gap too short");
    a_run_len: assert property (
        mst && !c2_ff.continuous_transfer_enable && $rose(SS_N_OUT)
        |-> low_ff inside {10'h040, 10'h080, 10'h100, 10'h200})
        else $error("single select time wrong");
    a_cont_hold: assert property (
        mst && c2_ff.continuous_transfer_enable && $rose(SS_N_OUT)
        |-> low_ff[5:0] == 6'h00 && low_ff != 10'h000)
        else $error("select not whole bytes");
    a_sample_still: assert property (
        mst && !SS_N_OUT && $changed(SCLK_OUT) && (SCLK_OUT !=
        c2_ff.clock_polarity_select) != c2_ff.clock_phase_select
        |-> $stable(MOSI_OUT)) else $error("data moved on sample edge");
    c_single: cover property (mst && $rose(SS_N_OUT));
    c_cont: cover property (c2_ff.continuous_transfer_enable
        && $fell(SS_N_OUT));
    c_od: cover property (c2_ff.open_drain_select && $fell(SS_N_OUT));
endmodule
bind spi_mode_configuration spi_mode_configuration_checker props (
    .CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .CYC_IN(CYC_IN),
    .STB_IN(STB_IN), .WE_IN(WE_IN), .ADR_IN(ADR_IN), .SEL_IN(SEL_IN),
    .DAT_IN(DAT_IN), .ACK_OUT(ACK_OUT), .SCLK_OUT(SCLK_OUT),
    .SCLK_OE_OUT(SCLK_OE_OUT), .MOSI_OUT(MOSI_OUT),
    .MOSI_OE_OUT(MOSI_OE_OUT), .SS_N_OUT(SS_N_OUT),
    .SS_N_OE_OUT(SS_N_OE_OUT), .PULLUP_EN_OUT(PULLUP_EN_OUT));

// File: spi_far_end.sv
// Behavioural serial slave standing at the far side of the port.
// Assumes the bench resolves the pin levels and sets the mode bits.
`timescale 1ns/1ps
module spi_far_end (
    input wire logic sclk_in,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    input wire logic cpol_in,
    input wire logic cpha_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic [7:0] sh;
    logic lead;
    logic act = 1'b0;
    initial miso_out = 1'b0;
    initial rx_out = 8'h00;
    always @(negedge ss_n_in)
    begin
        act = 1'b1;
        sh = tx_in;
        miso_out = cpha_in ? ~miso_out : sh[7];
        if (!cpha_in)
            sh = {sh[6:0], sh[7]};
    end
    // Select may rise with the last edge, which still belongs to the frame
    // Released line shows the inverse of its last value
    always @(posedge ss_n_in)
    begin
        #1;
        act = 1'b0;
        miso_out = ~miso_out;
    end
    always @(sclk_in)
    begin
        lead = sclk_in != cpol_in;
        if (act && lead != cpha_in)
            rx_out = {rx_out[6:0], mosi_in};
        else if (act)
        begin
            miso_out = sh[7];
            sh = {sh[6:0], sh[7]};
        end
    end
endmodule

// File: tb_spi_mode_configuration.sv
// Self-checking bench for the serial port block and its settings.
// Assumes the far-side model and the checker are compiled first.
`timescale 1ns/1ps
module tb_spi_mode_configuration;
    import spi_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic tsclk = 1'b1;
    logic tmosi = 1'b0;
    logic tss_n = 1'b1;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic [7:0] ftx = 8'h00;
    logic [7:0] frx;
    logic [7:0] q;
    logic [31:0] rd;
    logic ack, sco, scoe, mo, moe, mio, mioe, sso, ssoe, pu, fmiso;
    int n_mismatch = 0;
    int compares = 0;
    int k;
    // Released select and data pins are pulled high; released clock follows tsclk
    wire sclk_w = scoe ? sco : tsclk;
    wire ss_w = ssoe ? sso : 1'b1;
    wire mosi_w = moe ? mo : 1'b1;
    always #5 clk = ~clk;
    spi_mode_configuration dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n),
        .CYC_IN(cyc), .STB_IN(stb), .WE_IN(we), .ADR_IN(adr),
        .SEL_IN(sel), .DAT_IN(dat), .DAT_OUT(rd), .ACK_OUT(ack),
        .SCLK_IN(sclk_w), .SCLK_OUT(sco), .SCLK_OE_OUT(scoe),
        .MOSI_IN(tmosi), .MOSI_OUT(mo), .MOSI_OE_OUT(moe),
        .MISO_IN(fmiso), .MISO_OUT(mio), .MISO_OE_OUT(mioe),
        .SS_N_IN(tss_n), .SS_N_OUT(sso), .SS_N_OE_OUT(ssoe),
        .PULLUP_EN_OUT(pu));
    spi_far_end far (.sclk_in(sclk_w), .ss_n_in(ss_w), .mosi_in(mosi_w),
        .cpol_in(cpol), .cpha_in(cpha), .tx_in(ftx), .miso_out(fmiso),
        .rx_out(frx));
    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic close_out();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic stall(input string s);
        n_mismatch++;
        $display("CHECK FAILED %s exp done got timeout", s);
        close_out();
    endtask
    task automatic wb(input logic w, input logic [7:0] i,
        input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {2'b00, i, 2'b00};
        dat <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        q = rd[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        if (k >= 20)
            stall("bus ack");
    endtask
    task automatic wait_ss(input logic v);
        k = 0;
        while (ss_w !== v && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 400)
            stall("select");
    endtask
    task automatic t_reset();
        wb(1'b0, CFG1_IDX, 8'h00);
        chk("cfg1", 8'h10, q);
        wb(1'b0, CFG2_IDX, 8'h00);
        chk("cfg2", 8'h01, q);
        chk("oe", 8'h00, {4'h0, scoe, moe, mioe, ssoe});
        chk("pullup", 8'h01, {7'h0, pu});
        wb(1'b0, 8'h10, 8'h00);
        chk("unmapped", 8'h00, q);
        wb(1'b0, STAT_IDX, 8'h00);
        chk("status", 8'h00, q);
        $display("reset test done");
    endtask
    task automatic t_master();
        logic [7:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 8'h51 | 8'(i << 2);
            cpol <= i[1];
            cpha <= i[0];
            ftx <= 8'h96 ^ 8'(i);
            wb(1'b1, CFG2_IDX, m);
            wb(1'b0, CFG2_IDX, 8'h00);
            chk("cfg2", m, q);
            chk("sclk idle", {7'h0, i[1]}, {7'h0, sclk_w});
            wb(1'b1, TXD_IDX, 8'h3c + 8'(i));
            wait_ss(1'b0);
            wait_ss(1'b1);
            chk("far rx", 8'h3c + 8'(i), frx);
            wb(1'b0, RXD_IDX, 8'h00);
            chk("rx data", 8'h96 ^ 8'(i), q);
            chk("gap", 8'h01, {7'h0, ss_w});
        end
        $display("master modes test done");
    endtask
    task automatic t_cont();
        ftx <= 8'h5a;
        cpol <= 1'b0;
        cpha <= 1'b0;
        wb(1'b1, CFG2_IDX, 8'hf1);
        repeat (3) @(posedge clk);
        chk("pullup", 8'h00, {7'h0, pu});
        wb(1'b1, TXD_IDX, 8'h11);
        wait_ss(1'b0);
        wb(1'b1, TXD_IDX, 8'he7);
        wait_ss(1'b1);
        chk("held", 8'h01, {7'h0, k > 100});
        chk("far rx", 8'he7, frx);
        wb(1'b0, RXD_IDX, 8'h00);
        chk("rx data", 8'h5a, q);
        wb(1'b1, CFG2_IDX, 8'h01);
        repeat (3) @(posedge clk);
        chk("oe off", 8'h00, {4'h0, scoe, moe, mioe, ssoe});
        $display("continuous test done");
    endtask
    task automatic t_slave();
        logic [7:0] b;
        logic [7:0] g;
        b = 8'ha5;
        wb(1'b1, CFG1_IDX, 8'h18);
        wb(1'b1, CFG2_IDX, 8'h41);
        wb(1'b1, TXD_IDX, 8'hc3);
        tsclk <= 1'b0;
        // Clock settles low before select opens the frame
        @(posedge clk);
        tss_n <= 1'b0;
        #33;
        for (int j = 7; j >= 0; j--)
        begin
            tmosi = b[j];
            #40;
            g[j] = mio;
            tsclk = 1'b1;
            #40;
            tsclk = 1'b0;
        end
        #40;
        tss_n = 1'b1;
        wb(1'b0, RXD_IDX, 8'h00);
        chk("slave rx", 8'ha5, q);
        chk("slave tx", 8'hc3, g);
        wb(1'b0, STAT_IDX, 8'h00);
        chk("status", 8'h00, q);
        $display("slave test done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_master();
        t_cont();
        t_slave();
        close_out();
    end
endmodule
